// ### verilog/cihbp_bus_port.sv
`timescale 1ns/1ps
// Function
// RULE_01 - muxed bus latches six address bits
// RULE_02 - muxed read drives data during strobe
// RULE_03 - unimplemented register read stays undriven
// RULE_04 - muxed write loads data on strobe
// RULE_05 - select low and high lines pick device
// RULE_06 - sample address, ack, select under strobe
// RULE_07 - both muxed strobes low resets device
// RULE_08 - pending and enabled pulls request low
// RULE_09 - ack with pending blocks lower chain
// RULE_10 - ack cycle data strobe drives vector
// RULE_11 - vector sets under service, holds chain
// RULE_12 - chain out high only when permitted
// RULE_13 - claim ack only with chain in high
// RULE_14 - two lines select ports or control
// RULE_15 - direct bus acts only when enabled; the code serves ack reads and the strobe reset without chip enable
// RULE_16 - direct read drives data under strobe
// RULE_17 - direct ack read drives vector if highest
// RULE_18 - direct write accepted on write strobe
// RULE_19 - both direct strobes low resets device
// RULE_20 - ack held stable, clock synchronous
// RULE_21 - peripheral clock runs control logic
// RULE_22 - build time choice of bus variant
module cihbp_bus_port
    import cihbp_pkg::*;
#(
    parameter bit MUXED   = 1'b1,
    parameter int SOURCES = 3
) (
    // clock and reset
    input  wire logic               mclk,
    input  wire logic               resetn,
    // multiplexed bus
    input  wire logic               addr_strobe_n,
    input  wire logic               data_strobe_n,
    input  wire logic               readNotWrite,
    input  wire logic               select_low_n,
    input  wire logic               select_high,
    // non-multiplexed bus
    input  wire logic [1:0]         reg_select_lines,
    input  wire logic               chipEnable_n,
    input  wire logic               readStrobe_n,
    input  wire logic               writeStrobe_n,
    // shared data pins
    input  wire logic [7:0]         dataIn,
    output logic      [7:0]         dataOut,
    output logic                    dataOe,
    // interrupt chain
    input  wire logic               vector_ack_n,
    input  wire logic               chain_priority_in,
    output logic                    chain_priority_out,
    output logic                    intReqOut,
    output logic                    intReqOe,
    // internal side
    input  wire logic [SOURCES-1:0] srcEvent,
    input  wire logic [SOURCES-1:0] srcClear,
    input  wire logic               intEnable,
    input  wire logic [7:0]         vectorValue,
    output logic [SOURCES-1:0]      pending_flag,
    output logic [SOURCES-1:0]      under_service_flag,
    output logic                    strobeReset
);
    initial begin
        if (SOURCES < 1 || SOURCES > 8) $error("SOURCES out of range");
    end

    // one-hot steps of the direct control access
    typedef enum logic [1:0] {
        CTRL_PTR  = 2'b01,
        CTRL_DATA = 2'b10
    } cihbp_ctrl_e;
    cihbp_ctrl_e          ctrlState;

    logic [REG_IDX_W-1:0] regIdx;
    logic                 ackLatched;
    logic                 selLatched;
    logic                 busSelected;
    logic                 rdActive;
    logic                 wrActive;
    logic                 ackActive;
    logic                 rdPrev;
    logic                 wrPrev;
    logic                 wrPulse;
    logic                 rdStart;
    logic                 ackClaim;
    logic                 anyPending;
    logic                 anyService;
    logic                 fullReset;
    logic [7:0]           storeData;
    logic [REG_IDX_W-1:0] accIdx;
    logic [SOURCES-1:0]   topPending;
    logic                 vecHold;
    logic                 ctrlAccess;
    logic                 ptrLoad;

    // the whole block runs on the peripheral clock, strobes taken as synchronous [RULE_21]
    assign fullReset = MUXED ? (!addr_strobe_n && !data_strobe_n)    // [RULE_07]
                             : (!readStrobe_n && !writeStrobe_n);    // [RULE_19]
    assign strobeReset = fullReset;

    // address phase capture; select low is latched, select high is live [RULE_06]
    always_ff @(posedge mclk) begin
        if (!resetn || fullReset) begin
            regIdx     <= '0;
            ackLatched <= 1'b0;
            selLatched <= 1'b0;
        end else if (MUXED && !addr_strobe_n) begin
            regIdx     <= dataIn[REG_IDX_W-1:0];    // [RULE_01]
            ackLatched <= !vector_ack_n;
            selLatched <= !select_low_n;
        end else if (!MUXED && ptrLoad) begin
            regIdx     <= dataIn[REG_IDX_W-1:0];    // [RULE_14]
        end
    end

    // variant selection at build time, same internal access either way [RULE_22]
    always_comb begin
        if (MUXED) begin
            busSelected = selLatched && select_high;    // [RULE_05]
            ackActive   = ackLatched && !data_strobe_n && addr_strobe_n;
            rdActive    = busSelected && !ackLatched && !data_strobe_n && addr_strobe_n && readNotWrite;
            wrActive    = busSelected && !ackLatched && !data_strobe_n && addr_strobe_n && !readNotWrite;
            accIdx      = regIdx;
        end else begin
            busSelected = !chipEnable_n;    // [RULE_15]
            // ack level is trusted as clock synchronous and stable [RULE_20]
            ackActive   = !vector_ack_n && !readStrobe_n && writeStrobe_n;
            rdActive    = busSelected && vector_ack_n && !readStrobe_n && writeStrobe_n;    // [RULE_16]
            wrActive    = busSelected && vector_ack_n && !writeStrobe_n && readStrobe_n;    // [RULE_18]
            case (reg_select_lines)    // [RULE_14]
                SEL_PORTA: accIdx = IDX_PORTA_DATA;
                SEL_PORTB: accIdx = IDX_PORTB_DATA;
                SEL_PORTC: accIdx = IDX_PORTC_DATA;
                SEL_CTRL:  accIdx = regIdx;
                default:   accIdx = regIdx;
            endcase
        end
    end

    // one write per strobe, not one per clock
    always_ff @(posedge mclk) begin
        if (!resetn || fullReset) begin
            rdPrev <= 1'b0;
            wrPrev <= 1'b0;
        end else begin
            rdPrev <= rdActive || ackActive;
            wrPrev <= wrActive;
        end
    end
    assign wrPulse = wrActive && !wrPrev;    // [RULE_04]
    assign rdStart = (rdActive || ackActive) && !rdPrev;

    // direct control access uses the low data bits as pointer on a write;
    // two steps because two address lines cannot reach the whole store
    assign ctrlAccess = !MUXED && (rdStart || wrPulse) && !ackActive && reg_select_lines == SEL_CTRL;
    assign ptrLoad    = ctrlAccess && wrPulse && ctrlState == CTRL_PTR;    // [RULE_14]

    always_ff @(posedge mclk) begin
        if (!resetn || fullReset) begin
            ctrlState <= CTRL_PTR;
        end else if (ctrlAccess) begin
            case (ctrlState)
                CTRL_PTR:  ctrlState <= wrPulse ? CTRL_DATA : CTRL_PTR;
                CTRL_DATA: ctrlState <= CTRL_PTR;
                default:   ctrlState <= CTRL_PTR;
            endcase
        end
    end

    cihbp_reg_store #(
        .DEPTH(48)
    ) uStore (
        .mclk   (mclk),
        .resetn (resetn && !fullReset),
        .wrEn   (wrPulse && accIdx != IDX_VECTOR && !ptrLoad),
        .idx    (accIdx),
        .wrData (dataIn),
        .rdData (storeData)
    );

    // interrupt flags; a new event wins over a clear in the same cycle
    assign anyPending = |pending_flag;
    assign anyService = |under_service_flag;
    assign ackClaim   = chain_priority_in && anyPending && !anyService;    // [RULE_13]

    always_comb begin
        topPending = '0;
        for (int i = SOURCES - 1; i >= 0; i--) begin
            if (pending_flag[i]) topPending = '0;
            if (pending_flag[i]) topPending[i] = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn || fullReset) begin
            pending_flag <= '0;
        end else begin
            pending_flag <= (pending_flag & ~srcClear) | srcEvent;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn || fullReset) begin
            under_service_flag <= '0;
        end else if (ackActive && rdStart && ackClaim) begin
            under_service_flag <= under_service_flag | topPending;    // [RULE_11]
        end else begin
            under_service_flag <= under_service_flag & ~srcClear;
        end
    end

    // vector stays on the bus for the whole strobe, after service has already been set
    always_ff @(posedge mclk) begin
        if (!resetn || fullReset) begin
            vecHold <= 1'b0;
        end else begin
            vecHold <= ackActive && (ackClaim || vecHold);    // [RULE_10]
        end
    end

    // open drain request: only ever driven low [RULE_08]
    assign intReqOut = 1'b0;
    assign intReqOe  = anyPending && intEnable && !anyService;

    // chain out drops on service or on ack while requesting [RULE_09] [RULE_12]
    assign chain_priority_out = chain_priority_in && !anyService
                                && !(!vector_ack_n && anyPending);

    // data pins registered; unimplemented index leaves them released
    always_ff @(posedge mclk) begin
        if (!resetn || fullReset) begin
            dataOut <= 8'h00;
            dataOe  <= 1'b0;
        end else if (ackActive && (ackClaim || vecHold)) begin
            dataOut <= vectorValue;    // [RULE_10] [RULE_17]
            dataOe  <= 1'b1;
        end else if (rdActive && accIdx == IDX_VECTOR) begin
            dataOut <= vectorValue;
            dataOe  <= 1'b1;
        end else if (rdActive && accIdx <= IDX_LAST) begin
            dataOut <= storeData;    // [RULE_02]
            dataOe  <= !rdStart;
        end else begin
            dataOut <= 8'h00;
            dataOe  <= 1'b0;    // [RULE_03]
        end
    end

    AST_MUX_RESET: assert property (@(posedge mclk) disable iff (!resetn)
        (MUXED && !addr_strobe_n && !data_strobe_n) |=> (pending_flag == '0 && !dataOe))    // [RULE_07]
        else $error("strobe reset missed");
    AST_DIR_RESET: assert property (@(posedge mclk) disable iff (!resetn)
        (!MUXED && !readStrobe_n && !writeStrobe_n) |=> (under_service_flag == '0))    // [RULE_19]
        else $error("direct strobe reset missed");
    AST_UNMAPPED: assert property (@(posedge mclk) disable iff (!resetn)
        (rdActive && accIdx > IDX_LAST && accIdx != IDX_VECTOR && !ackActive) |=> !dataOe)    // [RULE_03]
        else $error("unmapped read drove bus");
    AST_REQ: assert property (@(posedge mclk) disable iff (!resetn)
        (anyPending && intEnable && !anyService) |-> intReqOe)    // [RULE_08]
        else $error("request not driven");
    AST_CHAIN_ACK: assert property (@(posedge mclk) disable iff (!resetn)
        (!vector_ack_n && anyPending) |-> !chain_priority_out)    // [RULE_09]
        else $error("chain not blocked on ack");
    AST_CHAIN_HIGH: assert property (@(posedge mclk) disable iff (!resetn)
        chain_priority_out |-> (chain_priority_in && !anyService))    // [RULE_12]
        else $error("chain out high illegally");
    AST_SERVICE_HOLD: assert property (@(posedge mclk) disable iff (!resetn || fullReset)
        (ackActive && rdStart && ackClaim) |=> (anyService && !chain_priority_out))    // [RULE_11]
        else $error("service flag not set");
    AST_VECTOR: assert property (@(posedge mclk) disable iff (!resetn || fullReset)
        (ackActive && ackClaim) |=> (dataOe && dataOut == $past(vectorValue)))    // [RULE_10]
        else $error("vector not driven");
    AST_NO_CLAIM: assert property (@(posedge mclk) disable iff (!resetn || fullReset)
        (ackActive && !chain_priority_in && !rdActive) |=> !dataOe)    // [RULE_13]
        else $error("vector driven without chain");
    AST_DISABLED: assert property (@(posedge mclk) disable iff (!resetn || fullReset)
        (!MUXED && chipEnable_n && !ackActive) |=> !dataOe)    // [RULE_15]
        else $error("driven while not enabled");


    // bus access checks
    AST_IDX_LATCH: assert property (@(posedge mclk) disable iff (!resetn || fullReset)
        (MUXED && !addr_strobe_n) |=> (regIdx == $past(dataIn[REG_IDX_W-1:0])))    // [RULE_01]
        else $error("index not latched");
    AST_ACK_LATCH: assert property (@(posedge mclk) disable iff (!resetn || fullReset)
        (MUXED && !addr_strobe_n) |=> (ackLatched == !$past(vector_ack_n) && selLatched == !$past(select_low_n)))    // [RULE_06]
        else $error("address phase not sampled");
    AST_MUX_READ: assert property (@(posedge mclk) disable iff (!resetn || fullReset)
        (MUXED && rdActive && !rdStart && accIdx <= IDX_LAST && accIdx != IDX_VECTOR)
        |=> (dataOe && dataOut == $past(storeData)))    // [RULE_02]
        else $error("muxed read data missing");
    AST_UNSELECTED: assert property (@(posedge mclk) disable iff (!resetn || fullReset)
        (MUXED && !select_high && !ackActive) |=> !dataOe)    // [RULE_05]
        else $error("driven while unselected");
    AST_WRITE_EDGE: assert property (@(posedge mclk) disable iff (!resetn || fullReset)
        wrPulse |=> !wrPulse)    // [RULE_04]
        else $error("second write in one strobe");
    AST_ACK_NO_WRITE: assert property (@(posedge mclk) disable iff (!resetn || fullReset)
        ackActive |-> !wrPulse)    // [RULE_10]
        else $error("write during acknowledge");

    // interrupt chain checks
    AST_VEC_STANDS: assert property (@(posedge mclk) disable iff (!resetn || fullReset)
        (ackActive && vecHold) |=> dataOe)    // [RULE_10]
        else $error("vector dropped under strobe");
    AST_SERVICE_KEEP: assert property (@(posedge mclk) disable iff (!resetn)
        anyService |-> !chain_priority_out)    // [RULE_11]
        else $error("chain open under service");
    AST_REQ_OFF: assert property (@(posedge mclk) disable iff (!resetn)
        !intEnable |-> !intReqOe)    // [RULE_08]
        else $error("request while disabled");
    AST_PEND_SET: assert property (@(posedge mclk) disable iff (!resetn || fullReset)
        (srcEvent != '0) |=> ((pending_flag & $past(srcEvent)) == $past(srcEvent)))    // [RULE_08]
        else $error("pending flag not set");
    AST_CHAIN_IN_LOW: assert property (@(posedge mclk) disable iff (!resetn)
        !chain_priority_in |-> !chain_priority_out)    // [RULE_12]
        else $error("chain passed without input");

    // direct bus checks
    AST_DIR_READ: assert property (@(posedge mclk) disable iff (!resetn || fullReset)
        (!MUXED && rdActive && !rdStart && accIdx <= IDX_LAST && accIdx != IDX_VECTOR)
        |=> (dataOe && dataOut == $past(storeData)))    // [RULE_16]
        else $error("direct read data missing");
    AST_DIR_MAP: assert property (@(posedge mclk) disable iff (!resetn)
        (!MUXED && reg_select_lines == SEL_PORTA) |-> (accIdx == IDX_PORTA_DATA))    // [RULE_14]
        else $error("port line mapping wrong");
    AST_PTR_LOAD: assert property (@(posedge mclk) disable iff (!resetn || fullReset)
        ptrLoad |=> (regIdx == $past(dataIn[REG_IDX_W-1:0]) && ctrlState == CTRL_DATA))    // [RULE_14]
        else $error("control pointer not loaded");
    AST_CTRL_ONEHOT: assert property (@(posedge mclk) disable iff (!resetn)
        $onehot(ctrlState))    // [RULE_14]
        else $error("control step not one-hot");
    AST_DIR_WRITE_GATE: assert property (@(posedge mclk) disable iff (!resetn)
        (!MUXED && chipEnable_n) |-> !wrPulse)    // [RULE_15]
        else $error("write while not enabled");

    // scenario coverage
    COV_READ:  cover property (@(posedge mclk) rdActive && dataOe);
    COV_WRITE: cover property (@(posedge mclk) wrPulse);
    COV_ACK:   cover property (@(posedge mclk) ackActive && ackClaim);
    COV_CTRL:  cover property (@(posedge mclk) ptrLoad);
    COV_CLASH: cover property (@(posedge mclk) fullReset && resetn);
endmodule

// ### verilog/cihbp_pkg.sv
package cihbp_pkg;
    // register index width and the four direct-address selections
    localparam int          REG_IDX_W      = 6;
    localparam logic [1:0]  SEL_PORTA      = 2'h0;
    localparam logic [1:0]  SEL_PORTB      = 2'h1;
    localparam logic [1:0]  SEL_PORTC      = 2'h2;
    localparam logic [1:0]  SEL_CTRL       = 2'h3;
    // internal indices used for direct port data access and the vector, then reset values
    localparam logic [5:0]  IDX_PORTC_DATA = 6'h0F;
    localparam logic [5:0]  IDX_PORTB_DATA = 6'h0E;
    localparam logic [5:0]  IDX_PORTA_DATA = 6'h0D;
    localparam logic [5:0]  IDX_VECTOR     = 6'h1F;
    localparam logic [7:0]  VECTOR_RESET   = 8'h00;
    localparam logic [7:0]  REG_RESET      = 8'h00;
    // implemented index span of the register store
    localparam logic [5:0]  IDX_LAST       = 6'h2F;
endpackage

// ### verilog/cihbp_reg_store.sv
`timescale 1ns/1ps
module cihbp_reg_store
    import cihbp_pkg::*;
#(
    parameter int DEPTH = 48
) (
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 resetn,
    // access
    input  wire logic                 wrEn,
    input  wire logic [REG_IDX_W-1:0] idx,
    input  wire logic [7:0]           wrData,
    output logic      [7:0]           rdData
);
    initial begin
        if (DEPTH < 1 || DEPTH > 64) $error("DEPTH out of range");
    end

    logic [7:0] mem [DEPTH];

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            for (int i = 0; i < DEPTH; i++) mem[i] <= REG_RESET;
        end else if (wrEn && int'(idx) < DEPTH) begin
            mem[idx] <= wrData;
        end
    end

    // registered read keeps the bus drive glitch free
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rdData <= REG_RESET;
        end else if (int'(idx) < DEPTH) begin
            rdData <= mem[idx];
        end else begin
            rdData <= REG_RESET;
        end
    end
endmodule

// ### testbench/cihbp_cpu_model.sv
`timescale 1ns/1ps
module cihbp_cpu_model (
    // clock
    input  wire logic       mclk,
    // device answer
    input  wire logic [7:0] dataOut,
    input  wire logic       dataOe,
    // bus drive
    output logic            addr_strobe_n,
    output logic            data_strobe_n,
    output logic            readNotWrite,
    output logic            select_low_n,
    output logic            select_high,
    output logic            vector_ack_n,
    output logic [7:0]      cpuData
);
    initial begin
        addr_strobe_n = 1'b1;
        data_strobe_n = 1'b1;
        readNotWrite  = 1'b1;
        select_low_n  = 1'b1;
        select_high   = 1'b0;
        vector_ack_n  = 1'b1;
        cpuData       = 8'hA5;
    end
    // one full cycle; ack stays put from address phase to release
    task automatic access(input logic rnw, input logic ack, input logic sel, input logic [7:0] addr,
                          input logic [7:0] wdata, output logic [7:0] rdata, output logic driven);
        driven = 1'b0;
        rdata  = 8'h00;
        @(posedge mclk);
        addr_strobe_n <= 1'b0;
        select_low_n  <= ~sel;
        select_high   <= sel;
        vector_ack_n  <= ack;
        readNotWrite  <= rnw;
        cpuData       <= addr;
        @(posedge mclk);
        addr_strobe_n <= 1'b1;
        cpuData       <= rnw ? ~addr : wdata;
        @(posedge mclk);
        data_strobe_n <= 1'b0;
        repeat (4) begin
            @(posedge mclk);
            if (dataOe === 1'b1) begin
                driven = 1'b1;
                rdata  = dataOut;
            end
        end
        data_strobe_n <= 1'b1;
        @(posedge mclk);
        // released bus must not keep showing the last byte
        cpuData       <= ~cpuData;
        select_low_n  <= 1'b1;
        select_high   <= 1'b0;
        vector_ack_n  <= 1'b1;
    endtask
    // both strobes low together, which the device treats as a reset
    task automatic collide();
        @(posedge mclk);
        addr_strobe_n <= 1'b0;
        data_strobe_n <= 1'b0;
        @(posedge mclk);
        @(posedge mclk);
        addr_strobe_n <= 1'b1;
        data_strobe_n <= 1'b1;
    endtask
endmodule

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import cihbp_pkg::*;
    logic       mclk = 1'b0;
    logic       resetn = 1'b0;
    logic       asN, dsN, rnw, selLowN, selHigh, ackN, dataOe, intReqOut, intReqOe, chainOut, strobeReset;
    logic [7:0] cpuData, dataOut, dataIn;
    logic [2:0] srcEvent = 3'h0, srcClear = 3'h0, pending, service;
    logic       intEnable = 1'b0, chainIn = 1'b1;
    logic [7:0] vectorValue = 8'h00;
    logic [7:0] mem [0:47];
    logic [7:0] rd, wd, r;
    logic [5:0] idx;
    logic       drv;
    int         fails = 0, n_tests = 0;
    logic [1:0] dLines = 2'h0;
    logic       dCeN = 1'b1, dRdN = 1'b1, dWrN = 1'b1, dAckN = 1'b1, dOe, dChain, dStrobe;
    logic [7:0] dWd = 8'h00, dIn, dOut;
    logic [2:0] dEv = 3'h0, dPend, dServ;
    logic [8:0] got;
    always #12.5 mclk = ~mclk;
    // wire level of the shared bus
    assign dataIn = dataOe ? dataOut : cpuData;
    cihbp_bus_port cihbp_bus_port_i (.mclk(mclk), .resetn(resetn), .addr_strobe_n(asN), .data_strobe_n(dsN),
        .readNotWrite(rnw), .select_low_n(selLowN), .select_high(selHigh), .reg_select_lines(2'h0),
        .chipEnable_n(1'b1), .readStrobe_n(1'b1), .writeStrobe_n(1'b1), .dataIn(dataIn), .dataOut(dataOut),
        .dataOe(dataOe), .vector_ack_n(ackN), .chain_priority_in(chainIn), .chain_priority_out(chainOut),
        .intReqOut(intReqOut), .intReqOe(intReqOe), .srcEvent(srcEvent), .srcClear(srcClear),
        .intEnable(intEnable), .vectorValue(vectorValue), .pending_flag(pending),
        .under_service_flag(service), .strobeReset(strobeReset));
    cihbp_cpu_model cihbp_cpu_model_i (.mclk(mclk), .dataOut(dataOut), .dataOe(dataOe), .addr_strobe_n(asN),
        .data_strobe_n(dsN), .readNotWrite(rnw), .select_low_n(selLowN), .select_high(selHigh),
        .vector_ack_n(ackN), .cpuData(cpuData));
    // second instance in the direct bus variant
    cihbp_bus_port #(.MUXED(1'b0)) cihbp_bus_port_dir_i (.mclk(mclk), .resetn(resetn), .addr_strobe_n(1'b1),
        .data_strobe_n(1'b1), .readNotWrite(1'b1), .select_low_n(1'b1), .select_high(1'b0),
        .reg_select_lines(dLines), .chipEnable_n(dCeN), .readStrobe_n(dRdN), .writeStrobe_n(dWrN), .dataIn(dIn),
        .dataOut(dOut), .dataOe(dOe), .vector_ack_n(dAckN), .chain_priority_in(1'b1), .chain_priority_out(dChain),
        .intReqOut(), .intReqOe(), .srcEvent(dEv), .srcClear(3'h0), .intEnable(1'b1), .vectorValue(vectorValue),
        .pending_flag(dPend), .under_service_flag(dServ), .strobeReset(dStrobe));
    assign dIn = dOe ? dOut : dWd;
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (fails == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // driven flag and byte a plain read of one index should return
    function automatic logic [8:0] expect_read(input logic [5:0] i);
        if (i == IDX_VECTOR)
            return {1'b1, vectorValue};
        if (i > IDX_LAST)
            return 9'h000;
        return {1'b1, mem[i]};
    endfunction
    task automatic rw(input logic rd_n, input logic ack, input logic sel, input logic [5:0] i, input logic [7:0] d);
        r = $urandom;
        cihbp_cpu_model_i.access(rd_n, ack, sel, {r[7:6], i}, d, rd, drv);
    endtask
    // direct bus cycle; lines, enable and ack settle one edge before the strobe
    task automatic dacc(input logic rdn, input logic ack, input logic [1:0] ln, input logic ce,
                        input logic [7:0] w, output logic [8:0] seen);
        seen = 9'h000;
        @(posedge mclk);
        dLines <= ln;
        dCeN   <= ~ce;
        dAckN  <= ~ack;
        dWd    <= w;
        @(posedge mclk);
        if (rdn) dRdN <= 1'b0;
        else dWrN <= 1'b0;
        repeat (3) begin
            @(posedge mclk);
            if (dOe === 1'b1) seen = {1'b1, dOut};
        end
        dRdN <= 1'b1;
        dWrN <= 1'b1;
        @(posedge mclk);
        dCeN  <= 1'b1;
        dAckN <= 1'b1;
    endtask
    initial begin
        #(25 * 8000);
        fails++;
        complete_run();
    end
    initial begin
        void'($urandom(32'h419945C2));
        for (int k = 0; k < 48; k++) mem[k] = REG_RESET;
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        vectorValue <= $urandom;
        @(posedge mclk);
        check({1'b0, pending, service, dataOe, intReqOe}, 9'h000);
        // random writes with random upper address bits, then random reads over the whole index span
        for (int k = 0; k < 24; k++) begin
            idx = 6'($urandom_range(0, 47));
            wd = $urandom;
            rw(1'b0, 1'b1, 1'b1, idx, wd);
            if (idx != IDX_VECTOR) mem[idx] = wd;
            idx = 6'($urandom);
            rw(1'b1, 1'b1, 1'b1, idx, 8'h00);
            check({drv, rd}, expect_read(idx));
        end
        foreach (mem[k]) begin
            rw(1'b1, 1'b1, 1'b1, 6'(k), 8'h00);
            check({drv, rd}, expect_read(6'(k)));
        end
        for (int k = 6'h30; k < 6'h40; k++) begin
            rw(1'b1, 1'b1, 1'b1, 6'(k), 8'h00);
            check({drv, rd}, 9'h000);
        end
        // deselected write and read
        rw(1'b0, 1'b1, 1'b0, 6'h05, ~mem[5]);
        check({drv, rd}, 9'h000);
        rw(1'b1, 1'b1, 1'b0, 6'h05, 8'h00);
        check({drv, rd}, 9'h000);
        rw(1'b1, 1'b1, 1'b1, 6'h05, 8'h00);
        check({drv, rd}, expect_read(6'h05));
        // interrupt request gated by enable
        srcEvent <= 3'h1;
        @(posedge mclk);
        srcEvent <= 3'h0;
        repeat (2) @(posedge mclk);
        check({6'h0, pending, intReqOe}, {6'h0, 3'h1, 1'b0});
        intEnable <= 1'b1;
        repeat (2) @(posedge mclk);
        check({7'h0, intReqOe, chainOut}, 9'h003);
        chainIn <= 1'b0;
        repeat (2) @(posedge mclk);
        check({8'h0, chainOut}, 9'h000);
        rw(1'b1, 1'b0, 1'b1, IDX_VECTOR, 8'h00);
        check({drv, service, 5'h0}, 9'h000);
        chainIn <= 1'b1;
        repeat (2) @(posedge mclk);
        rw(1'b1, 1'b0, 1'b1, IDX_VECTOR, 8'h00);
        check({drv, rd}, {1'b1, vectorValue});
        check({5'h0, service, chainOut}, 9'h002);
        srcClear <= 3'h1;
        @(posedge mclk);
        srcClear <= 3'h0;
        repeat (2) @(posedge mclk);
        check({6'h0, service}, 9'h000);
        // strobe collision clears flags and registers
        srcEvent <= 3'h2;
        @(posedge mclk);
        srcEvent <= 3'h0;
        cihbp_cpu_model_i.collide();
        repeat (2) @(posedge mclk);
        check({3'h0, pending, service}, 9'h000);
        for (int k = 0; k < 48; k++) mem[k] = REG_RESET;
        rw(1'b1, 1'b1, 1'b1, 6'h05, 8'h00);
        check({drv, rd}, expect_read(6'h05));
        // direct bus: port lines, enable, control pointer, vector, strobe reset
        wd = $urandom;
        dacc(1'b0, 1'b0, SEL_PORTB, 1'b1, wd, got);
        dacc(1'b1, 1'b0, SEL_PORTB, 1'b1, 8'h00, got);
        check(got, {1'b1, wd});
        dacc(1'b1, 1'b0, SEL_PORTA, 1'b1, 8'h00, got);
        check(got, {1'b1, REG_RESET});
        dacc(1'b0, 1'b0, SEL_PORTC, 1'b0, ~wd, got);
        dacc(1'b1, 1'b0, SEL_PORTC, 1'b0, 8'h00, got);
        check(got, 9'h000);
        dacc(1'b1, 1'b0, SEL_PORTC, 1'b1, 8'h00, got);
        check(got, {1'b1, REG_RESET});
        dacc(1'b0, 1'b0, SEL_CTRL, 1'b1, {2'h0, IDX_PORTB_DATA}, got);
        dacc(1'b1, 1'b0, SEL_CTRL, 1'b1, 8'h00, got);
        check(got, {1'b1, wd});
        dEv <= 3'h4;
        @(posedge mclk);
        dEv <= 3'h0;
        dacc(1'b1, 1'b1, SEL_PORTA, 1'b0, 8'h00, got);
        check(got, {1'b1, vectorValue});
        check({5'h0, dServ, dChain}, 9'h008);
        dRdN <= 1'b0;
        dWrN <= 1'b0;
        @(posedge mclk);
        check({8'h0, dStrobe}, 9'h001);
        dRdN <= 1'b1;
        dWrN <= 1'b1;
        @(posedge mclk);
        check({3'h0, dPend, dServ}, 9'h000);
        dacc(1'b1, 1'b0, SEL_PORTB, 1'b1, 8'h00, got);
        check(got, {1'b1, REG_RESET});
        complete_run();
    end
endmodule
